/* design/fag_top.sv */
// Purpose: access gate and decode for flash control and erase block registers
// Assumes: wishbone classic slave, 32-bit data, byte registers in low lane
// Notes:   the comparator is analog; its digital output arrives here unsynchronised
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/100ps
module fag_top (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [17:0] adr_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// pins
	input  wire logic        prog_voltage_hv_i,
	input  wire logic        standby_pin_n_i,
	input  wire logic [1:0]  mode_i,
	// flash side read of unimplemented range
	input  wire logic [16:0] flash_adr_i,
	output logic             flash_hole_o,
	// external space forwarding, standby and register outputs
	output logic             ext_fwd_o,
	output logic             hw_standby_o,
	output logic [7:0]       flash_control_o,
	output logic [7:0]       erase_block_select_lo_o,
	output logic [7:0]       erase_block_select_hi_o
);
	// synchronised pins and the delayed flag
	logic              hv_s;
	logic              standby_pin_s;
	logic              hv_d_r;
	// register contents
	logic [7:0]        ctrl_r;
	logic [7:0]        ctrl_nxt;
	logic [7:0]        eblo_r;
	logic [7:0]        eblo_nxt;
	logic [7:0]        ebhi_r;
	logic [7:0]        ebhi_nxt;
	// bus answer
	logic [31:0]       dat_r;
	logic [31:0]       dat_nxt;
	logic              ack_r;
	logic              ack_nxt;
	logic              fwd_r;
	logic              fwd_nxt;
	// standby and unimplemented range
	logic              standby_pin_r;
	logic              standby_pin_nxt;
	logic              hole_r;
	logic              hole_nxt;
	// decode
	fag_pkg::fag_tgt_t tgt;
	logic              req;
	logic              is_ctrl_adr;
	logic              hit_ctrl;
	logic              hit_eblo;
	logic              hit_ebhi;
	logic              hit_stat;

	// ==========================================================
	// synchronised comparator and standby pin
	fag_sync #(.W(2)) u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   ({standby_pin_n_i, prog_voltage_hv_i}),
		.q_o   ({standby_pin_s, hv_s})
	);

	// decode target from mode and flag; the sync delay keeps a cycle stable
	function automatic fag_pkg::fag_tgt_t fag_route(input logic hv, input logic [1:0] md);
		if (hv) begin
			fag_route = (md == fag_pkg::FAG_MODE_1) ? fag_pkg::FAG_TGT_RSVD : fag_pkg::FAG_TGT_CTRL;
		end else begin
			fag_route = (md == fag_pkg::FAG_MODE_3) ? fag_pkg::FAG_TGT_RSVD : fag_pkg::FAG_TGT_EXT;
		end
	endfunction

	// one address match, shared by every select line below
	function automatic logic fag_hit(input logic [17:0] adr, input logic [17:0] reg_adr);
		fag_hit = (adr == reg_adr);
	endfunction

	// ==========================================================
	// address decode
	// the route uses the delayed flag so a bus cycle never sees it move
	always_comb begin
		req = cyc_i && stb_i && !ack_r;
		hit_ctrl = fag_hit(adr_i, fag_pkg::FAG_ADR_CTRL);
		hit_eblo = fag_hit(adr_i, fag_pkg::FAG_ADR_EBLK_LO);
		hit_ebhi = fag_hit(adr_i, fag_pkg::FAG_ADR_EBLK_HI);
		hit_stat = fag_hit(adr_i, fag_pkg::FAG_ADR_STATUS);
		is_ctrl_adr = hit_ctrl || hit_eblo || hit_ebhi;
		tgt = fag_route(hv_d_r, mode_i);
	end

	// ==========================================================
	// register file and bus answer
	always_comb begin
		ctrl_nxt = ctrl_r;
		eblo_nxt = eblo_r;
		ebhi_nxt = ebhi_r;
		dat_nxt  = dat_r;
		ack_nxt  = req;
		fwd_nxt  = 1'b0;
		// losing voltage drops the registers back to their reset state
		if (!hv_d_r || tgt != fag_pkg::FAG_TGT_CTRL) begin
			ctrl_nxt = fag_pkg::FAG_CTRL_RST;
			eblo_nxt = fag_pkg::FAG_EBLK_RST;
			ebhi_nxt = fag_pkg::FAG_EBLK_RST;
		end
		// only the first cycle of a request is taken; ack blocks a repeat
		if (req) begin
			dat_nxt = 32'h0000_0000;
			if (is_ctrl_adr) begin
				case (tgt)
					fag_pkg::FAG_TGT_CTRL: begin
						if (we_i && sel_i[0]) begin
							if (hit_ctrl) begin
								// hv bit written as one, not taken from software
								ctrl_nxt = {1'b1, dat_i[6:0]};
							end else if (hit_eblo) begin
								eblo_nxt = dat_i[7:0];
							end else begin
								ebhi_nxt = dat_i[7:0];
							end
						end
						if (hit_ctrl) begin
							dat_nxt = {24'h00_0000, ctrl_r};
						end else if (hit_eblo) begin
							dat_nxt = {24'h00_0000, eblo_r};
						end else begin
							dat_nxt = {24'h00_0000, ebhi_r};
						end
					end
					fag_pkg::FAG_TGT_RSVD: begin
						dat_nxt = {24'h00_0000, fag_pkg::FAG_ALL_ONES};
					end
					fag_pkg::FAG_TGT_EXT: begin
						fwd_nxt = 1'b1;
					end
					default: begin
						dat_nxt = 32'h0000_0000;
					end
				endcase
			end else if (hit_stat) begin
				// status shows the flag as the decode sees it, not the raw pin
				dat_nxt = {28'h000_0000, mode_i, standby_pin_r, hv_d_r};
			end
		end else begin
			dat_nxt = 32'h0000_0000;
		end
	end

	// ==========================================================
	// standby and unimplemented range
	always_comb begin
		standby_pin_nxt = !standby_pin_s;
		// hole flag lags the flash address by one cycle, like read data
		hole_nxt = (flash_adr_i >= fag_pkg::FAG_HOLE_LO) && (flash_adr_i <= fag_pkg::FAG_HOLE_HI);
	end

	// ==========================================================
	// state registers, synchronous reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_r <= fag_pkg::FAG_CTRL_RST;
			eblo_r <= fag_pkg::FAG_EBLK_RST;
			ebhi_r <= fag_pkg::FAG_EBLK_RST;
			dat_r  <= 32'h0000_0000;
			ack_r  <= 1'b0;
			fwd_r  <= 1'b0;
			standby_pin_r <= 1'b0;
			hole_r <= 1'b0;
			hv_d_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			eblo_r <= eblo_nxt;
			ebhi_r <= ebhi_nxt;
			dat_r  <= dat_nxt;
			ack_r  <= ack_nxt;
			fwd_r  <= fwd_nxt;
			standby_pin_r <= standby_pin_nxt;
			hole_r <= hole_nxt;
			hv_d_r <= hv_s;
		end
	end

	// ==========================================================
	// outputs, all registered
	assign dat_o                   = dat_r;
	assign ack_o                   = ack_r;
	assign ext_fwd_o               = fwd_r;
	assign hw_standby_o            = standby_pin_r;
	assign flash_hole_o            = hole_r;
	assign flash_control_o         = ctrl_r;
	assign erase_block_select_lo_o = eblo_r;
	assign erase_block_select_hi_o = ebhi_r;
endmodule

/* design/fag_pkg.sv */
// Purpose: shared constants for the flash access gate
// Assumes: byte-wide registers, one per aligned wishbone word
// Notes:   printed offsets are register indices; byte address is four times the index
package fag_pkg;
	// ==========================================================
	// register indices and byte addresses
	localparam logic [15:0] FAG_IDX_CTRL     = 16'hFF80;
	localparam logic [15:0] FAG_IDX_EBLK_LO  = 16'hFF82;
	localparam logic [15:0] FAG_IDX_EBLK_HI  = 16'hFF83;
	localparam logic [15:0] FAG_IDX_STATUS   = 16'hFF84;
	localparam logic [17:0] FAG_ADR_CTRL     = {FAG_IDX_CTRL, 2'b00};
	localparam logic [17:0] FAG_ADR_EBLK_LO  = {FAG_IDX_EBLK_LO, 2'b00};
	localparam logic [17:0] FAG_ADR_EBLK_HI  = {FAG_IDX_EBLK_HI, 2'b00};
	localparam logic [17:0] FAG_ADR_STATUS   = {FAG_IDX_STATUS, 2'b00};
	// ==========================================================
	// unimplemented array range, byte addresses on the flash side
	localparam logic [16:0] FAG_HOLE_LO      = 17'h0F780;
	localparam logic [16:0] FAG_HOLE_HI      = 17'h1FFFF;
	// ==========================================================
	// values
	localparam logic [7:0]  FAG_ALL_ONES     = 8'hFF;
	localparam logic [7:0]  FAG_CTRL_RST     = 8'h80;
	localparam logic [7:0]  FAG_EBLK_RST     = 8'h00;
	localparam int          FAG_CTRL_HV_BIT  = 7;
	localparam int          FAG_ST_HV_BIT    = 0;
	localparam int          FAG_ST_STANDBY_PIN_BIT  = 1;
	localparam int          FAG_ST_MODE_LSB  = 2;
	// ==========================================================
	// operating modes
	localparam logic [1:0]  FAG_MODE_1       = 2'h1;
	localparam logic [1:0]  FAG_MODE_2       = 2'h2;
	localparam logic [1:0]  FAG_MODE_3       = 2'h3;
	// ==========================================================
	// decode targets
	typedef enum logic [2:0] {
		FAG_TGT_CTRL = 3'b001,
		FAG_TGT_RSVD = 3'b010,
		FAG_TGT_EXT  = 3'b100
	} fag_tgt_t;
endpackage

/* design/fag_sync.sv */
// Purpose: two-flop level synchroniser
// Assumes: async level in, clk_i domain out
// Notes:   first stage feeds only the second
`timescale 1ns/100ps
module fag_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// level
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s1_nxt;
	logic [W-1:0] s2_r;
	logic [W-1:0] s2_nxt;

	// ==========================================================
	// stages
	always_comb begin
		s1_nxt = d_i;
		s2_nxt = s1_r;
	end

	// reset to low so the gate starts closed
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_r <= '0;
			s2_r <= '0;
		end else begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
		end
	end

	assign q_o = s2_r;
endmodule

/* dv/fag_sva.sv */
// Purpose: port checks of the flash access gate
// Assumes: one clock domain, levels held by the bench
// Notes:   voltage trusted after five steady samples
`timescale 1ns/100ps
module fag_sva (
	// clock, reset, bus, pins and state
	input wire logic		clk_i,
	input wire logic		rst_i,
	input wire logic		cyc_i,
	input wire logic		stb_i,
	input wire logic		we_i,
	input wire logic [17:0]	adr_i,
	input wire logic [31:0]	dat_o,
	input wire logic		ack_o,
	input wire logic		prog_voltage_hv_i,
	input wire logic [1:0]	mode_i,
	input wire logic [16:0]	flash_adr_i,
	input wire logic		flash_hole_o,
	input wire logic		ext_fwd_o,
	input wire logic [7:0]	flash_control_o
);
	logic [4:0]	v_r;
	// level history, a fresh edge may still race the synchroniser
	always_ff @(posedge clk_i) v_r <= {v_r[3:0], prog_voltage_hv_i};
	wire rq = cyc_i & stb_i & ~ack_o;
	wire cr = rq & adr_i == 18'h3FE00;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_next: assert property (rq |=> ack_o) else $error("ack late");
	a_hole_ones: assert property (1'b1 |=> flash_hole_o == ($past(flash_adr_i) >= 17'h0F780)) else $error("hole");
	a_rsvd_m1: assert property (cr & !we_i & v_r == 5'h1F & mode_i == 2'h1 |=> dat_o[7:0] == 8'hFF)
		else $error("rsvd m1");
	a_rsvd_m3: assert property (cr & !we_i & v_r == 5'h0 & mode_i == 2'h3 |=> dat_o[7:0] == 8'hFF)
		else $error("rsvd m3");
	a_ext_fwd: assert property (cr & v_r == 5'h0 & mode_i != 2'h3 |=> ext_fwd_o) else $error("ext");
	a_hv_local: assert property (cr & v_r == 5'h1F |=> !ext_fwd_o) else $error("ext hv");
	a_idle_rst: assert property (v_r == 5'h0 |-> flash_control_o == 8'h80) else $error("idle");
	a_ctrl_bit: assert property (cr & !we_i & v_r == 5'h1F |=> dat_o[7]) else $error("bit7");
	c_ext: cover property (ext_fwd_o);
	c_hole: cover property (flash_hole_o);
	c_rsvd: cover property (cr & v_r == 5'h1F & mode_i == 2'h1);
endmodule
bind fag_top fag_sva fag_sva_i (.*);

/* dv/fag_supply.sv */
// Purpose: programming supply beside the gate
// Assumes: comparator level follows the request
// Notes:   frozen while reset is held
`timescale 1ns/100ps
module fag_supply (
	// clock, reset, request and level
	input  wire logic	clk_i,
	input  wire logic	rst_i,
	input  wire logic	hv_req_i,
	output logic		hv_o = 1'b0
);
	// never moves under reset, so no change lands mid reset
	always @(posedge clk_i) if (!rst_i) hv_o <= hv_req_i;
endmodule

/* dv/tb_fag_top.sv */
// Purpose: scenario bench for the flash access gate
// Assumes: 100 MHz clock, supply model drives the flag
// Notes:   read data taken at the rising edge that samples ack high
`timescale 1ns/100ps
module tb_fag_top;
	logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, standby_pin_n_i = 1, hv_req = 0, ext;
	logic			ack_o, ext_fwd_o, hw_standby_o, flash_hole_o, prog_voltage_hv_i;
	logic [1:0]		mode_i = 2'h3;
	logic [17:0]	adr_i = 18'h0;
	logic [31:0]	dat_i = 32'h0, dat_o;
	logic [16:0]	flash_adr_i = 17'h0;
	logic [7:0]		q, flash_control_o, erase_block_select_lo_o, erase_block_select_hi_o;
	int				errors = 0, cmp_count = 0;
	// clock, supply model and block
	always #5 clk_i = ~clk_i;
	fag_supply fag_supply_i (.clk_i(clk_i), .rst_i(rst_i), .hv_req_i(hv_req), .hv_o(prog_voltage_hv_i));
	fag_top fag_top_i (
		.clk_i                   (clk_i),
		.rst_i                   (rst_i),
		.cyc_i                   (cyc_i),
		.stb_i                   (stb_i),
		.we_i                    (we_i),
		.sel_i                   (4'h1),
		.adr_i                   (adr_i),
		.dat_i                   (dat_i),
		.dat_o                   (dat_o),
		.ack_o                   (ack_o),
		.prog_voltage_hv_i       (prog_voltage_hv_i),
		.standby_pin_n_i         (standby_pin_n_i),
		.mode_i                  (mode_i),
		.flash_adr_i             (flash_adr_i),
		.flash_hole_o            (flash_hole_o),
		.ext_fwd_o               (ext_fwd_o),
		.hw_standby_o            (hw_standby_o),
		.flash_control_o         (flash_control_o),
		.erase_block_select_lo_o (erase_block_select_lo_o),
		.erase_block_select_hi_o (erase_block_select_hi_o)
	);
	// byte compare
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		errors += (g !== e);
		if (g !== e) $display("Error %s expected %h seen %h", n, e, g);
	endtask
	// classic cycle, held until ack is seen
	task wb(input logic w, input logic [17:0] a, input logic [7:0] d);
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, 24'h0, d};
		do @(posedge clk_i); while (ack_o !== 1'b1);
		// taken at the edge that samples ack, before the design updates
		{ext, q} = {ext_fwd_o, dat_o[7:0]};
		{cyc_i, stb_i, we_i} <= 3'b000;
	endtask
	// every mode code against both voltage levels; control never written, no program or erase bit
	task t_modes;
		for (int k = 0; k < 8; k++) begin
			{hv_req, mode_i} <= k[2:0];
			repeat (6) @(posedge clk_i);
			wb(1'b1, 18'h3FE08, 8'h5A);
			wb(1'b1, 18'h3FE0C, 8'hA5);
			wb(1'b0, 18'h3FE00, 8'h00);
			if (k[2] || k[1:0] == 2'h3) chk("ctrl", (k[2] && k[1:0] != 2'h1) ? 8'h80 : 8'hFF, q);
			chk("ext", {7'h0, !k[2] && k[1:0] != 2'h3}, {7'h0, ext});
			chk("erase", (k[2] && k[1:0] != 2'h1) ? 8'h5A : 8'h00, erase_block_select_lo_o);
			chk("erase hi", (k[2] && k[1:0] != 2'h1) ? 8'hA5 : 8'h00, erase_block_select_hi_o);
			chk("control", 8'h80, flash_control_o);
			wb(1'b0, 18'h3FE10, 8'h00);
			chk("status", {4'h0, k[1:0], 1'b0, k[2]}, q);
			wb(1'b0, 18'h0, 8'h00);
			chk("unmapped", 8'h00, q);
		end
	endtask
	// hole flag at its lower edge, with standby checked in the same steps
	task t_pins;
		for (int i = 0; i < 2; i++) begin
			@(posedge clk_i);
			{flash_adr_i, standby_pin_n_i} <= {i ? 17'h0F780 : 17'h0F77F, i == 0};
			repeat (4) @(posedge clk_i);
			@(negedge clk_i);
			chk("pins", {6'h0, i == 1, i == 1}, {6'h0, flash_hole_o, hw_standby_o});
		end
	endtask
	// counts and verdict
	task stop_test;
		$display("checks %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// reset, then the scenarios
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		t_modes;
		t_pins;
		stop_test;
	end
	// hang guard, a run needs about two hundred cycles
	initial begin
		repeat (5000) @(posedge clk_i);
		errors++;
		stop_test;
	end
endmodule
